/* File: core/dccb_pkg.sv */
/*
 * dccb_pkg: register offsets, field positions, reset values and timing
 * constants for the driver control/configuration register bank.
 * assumes a 125 MHz system clock.
 */
package dccb_pkg;
	localparam int          CLK_HZ          = 125_000_000;
	localparam logic [5:0]  ADDR_CTRL4      = 6'h04;
	localparam logic [5:0]  ADDR_CONFIG     = 6'h3f;
	localparam logic [15:0] CTRL4_RESET     = 16'h0000;
	localparam logic [15:0] CONFIG_RESET    = 16'h0000;
	// writable bits; all other bits are reserved and read zero
	localparam logic [15:0] CTRL4_WMASK     = 16'hff5f;
	localparam logic [15:0] CONFIG_WMASK    = 16'h0079;
	// control register 4 fields
	localparam int          C4_OUT9_OR      = 15;
	localparam int          C4_OUT8_OR      = 14;
	localparam int          C4_OUT7_OR      = 13;
	localparam int          C4_OUT6_OR      = 12;
	localparam int          C4_OUT9_PWM     = 11;
	localparam int          C4_OUT8_PWM     = 10;
	localparam int          C4_OUT7_PWM     = 9;
	localparam int          C4_OUT6_PWM     = 8;
	localparam int          C4_ECV_OR       = 6;
	localparam int          C4_ECV_PWM      = 4;
	localparam int          C4_SEL_LSB      = 0;
	// configuration register fields
	localparam int          CF_EC_OL_MASK   = 6;
	localparam int          CF_OUT1HS_MASK  = 5;
	localparam int          CF_OUT1LS_MASK  = 4;
	localparam int          CF_TWOL_MASK    = 3;
	localparam int          CF_WD_TRIG      = 0;
	// open-load status positions (status reg 2)
	localparam int          OL_OUT7         = 11;
	localparam int          OL_ECV          = 14;
	localparam int          OL_EC_FAST_DISCHARGE_CHANNEL         = 15;
	// current monitor selector
	localparam logic [3:0]  SEL_OFF         = 4'h0;
	localparam logic [3:0]  SEL_MAX         = 4'h9;
	// recovery rates in Hz, periods in cycles (round down)
	localparam int          RATE_SLOW_HZ    = 1700;
	localparam int          RATE_FAST_HZ    = 3000;
	localparam int          PER_SLOW        = CLK_HZ / RATE_SLOW_HZ;
	localparam int          PER_FAST        = CLK_HZ / RATE_FAST_HZ;
	// on-time portion of the recovery pattern, in eighths of the slow-rate period
	localparam int          DUTY_EIGHTHS    = 1;
	localparam int          NUM_OUT         = 5;
	localparam int          IDX_ECV         = 4;
endpackage : dccb_pkg

/* File: core/dccb_recovery.sv */
/*
 * dccb_recovery: overcurrent latch and auto-recovery timing for one
 * output. assumes oc_event is synchronous and recovery_tick is the
 * one-cycle period pulse of the selected recovery rate.
 */
`timescale 1ns/100ps
module dccb_recovery (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// control
	input  wire logic recovery_en,
	input  wire logic oc_event,
	input  wire logic status_clear,
	input  wire logic recovery_tick,
	input  wire logic duty_end,
	// result
	output logic      oc_status,
	output logic      drive_allow
);
	typedef struct packed {
		logic status;
		logic blocked;
	} dccb_rec_st_t;

	dccb_rec_st_t s_q;
	dccb_rec_st_t s_d;

	always_comb begin
		s_d = s_q;
		if (status_clear)
			s_d.status = 1'b0;
		if (recovery_en) begin
			// re-enable at each period start, drop after duty window
			if (recovery_tick)
				s_d.blocked = 1'b0;
			else if (duty_end && s_q.status)
				s_d.blocked = 1'b1;
		end else if (status_clear) begin
			s_d.blocked = 1'b0;
		end
		if (oc_event) begin
			s_d.status  = 1'b1;
			s_d.blocked = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign oc_status   = s_q.status;
	assign drive_allow = !s_q.blocked;

	property p_oc_blocks;
		@(posedge clk) disable iff (rst)
		oc_event |=> !drive_allow && oc_status;
	endproperty
	a_oc_blocks: assert property (p_oc_blocks)
		else $error("overcurrent did not block output");

	property p_latched_off;
		@(posedge clk) disable iff (rst)
		(!recovery_en && !drive_allow && !status_clear) |=> !drive_allow;
	endproperty
	a_latched_off: assert property (p_latched_off)
		else $error("output re-enabled without status clear");

	property p_recover;
		@(posedge clk) disable iff (rst)
		(recovery_en && recovery_tick && !oc_event) |=> drive_allow;
	endproperty
	a_recover: assert property (p_recover)
		else $error("output not reactivated at recovery period");
endmodule : dccb_recovery

/* File: core/dccb_top.sv */
/*
 * dccb_top: control register 4 and configuration register with output
 * recovery, pwm gating, current monitor select, open-load masking and
 * watchdog service. assumes a simple synchronous register port driven
 * by the serial interface front end; all inputs synchronous to clk.
 */
`timescale 1ns/100ps
// Notes on behaviour
// - recovery enable set: output returns after delay with set duty.
// - recovery enable clear: output stays off until status cleared by host.
// - enabled output with pwm gate set follows its pwm input level.
// - out8 uses pwm c, out7 pwm a, out6 pwm b.
// - ec voltage output with pwm gate set follows pwm a.
// - reserved control bits are written zero and read zero.
// - selector 0 off, 1 to 9 route high side current image.
// - configuration bits 15 to 8 written zero, read zero.
// - combined mask drops ec voltage, fast discharge, out7 open load.
// - out1 high side mask drops its open load from global flag.
// - out1 low side mask drops its open load from global flag.
// - warning/open-load mask keeps those out of global error flag.
// - watchdog service comes from config bit or control 1 bit 0.
// - recovery rate select 0 gives 1.7 kHz, 1 gives 3 kHz.
// - overcurrent sets status bit and disables the output driver.
module dccb_top (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// register port
	input  wire logic        reg_wr,
	input  wire logic [5:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	// external settings and service
	input  wire logic        recovery_rate_select,
	input  wire logic        ctrl1_wd_bit,
	output logic             watchdog_service,
	// outputs 6..9 and ec voltage: index 0..3 = out6..out9, 4 = ecv
	input  wire logic [4:0]  out_enable,
	input  wire logic [4:0]  oc_event,
	input  wire logic [4:0]  oc_status_clear,
	output logic      [4:0]  oc_status,
	output logic      [4:0]  drive_on,
	// pwm inputs
	input  wire logic        pwm_input_a,
	input  wire logic        pwm_input_b,
	input  wire logic        pwm_input_c,
	// current monitor
	output logic      [9:0]  current_monitor_pin,
	// open-load and warning aggregation
	input  wire logic [15:0] openload_status2,
	input  wire logic [1:0]  out1_undercurrent,
	input  wire logic        temp_warning,
	input  wire logic        other_errors,
	output logic             global_warn_openload_flag,
	output logic             global_error_flag
);
	typedef struct packed {
		logic [15:0] ctrl4;
		logic [15:0] config_r;
		logic        wd_last;
		logic        ctrl1_last;
		logic        wd_pulse;
		logic [16:0] div_cnt;
	} dccb_st_t;

	dccb_st_t s_q;
	dccb_st_t s_d;

	logic [16:0] period;
	logic        tick;
	logic        duty_end;
	logic [4:0]  rec_en;
	logic [4:0]  pwm_gate;
	logic [4:0]  pwm_src;
	logic [4:0]  allow;
	logic [3:0]  monitor_sel;

	function automatic logic [15:0] dccb_wr(input logic [15:0] data,
						input logic [15:0] mask);
		dccb_wr = data & mask;
	endfunction : dccb_wr

	// recovery period select
	assign period   = recovery_rate_select ?
			  17'(dccb_pkg::PER_FAST) :
			  17'(dccb_pkg::PER_SLOW);
	assign tick     = (s_q.div_cnt == 17'd0);
	assign duty_end = (s_q.div_cnt ==
			   17'((dccb_pkg::PER_SLOW * dccb_pkg::DUTY_EIGHTHS) / 8));

	always_comb begin
		s_d = s_q;
		if (s_q.div_cnt + 17'd1 >= period)
			s_d.div_cnt = 17'd0;
		else
			s_d.div_cnt = s_q.div_cnt + 17'd1;
		if (reg_wr && reg_addr == dccb_pkg::ADDR_CTRL4)
			s_d.ctrl4 = dccb_wr(reg_wdata,
					    dccb_pkg::CTRL4_WMASK);
		if (reg_wr && reg_addr == dccb_pkg::ADDR_CONFIG)
			s_d.config_r = dccb_wr(reg_wdata,
					       dccb_pkg::CONFIG_WMASK);
		s_d.wd_last    = s_q.config_r[dccb_pkg::CF_WD_TRIG];
		s_d.ctrl1_last = ctrl1_wd_bit;
		// a toggle on either source is one service event
		s_d.wd_pulse = (s_q.config_r[dccb_pkg::CF_WD_TRIG] != s_q.wd_last) ||
			       (ctrl1_wd_bit != s_q.ctrl1_last);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q          <= '0;
			s_q.ctrl4    <= dccb_pkg::CTRL4_RESET;
			s_q.config_r <= dccb_pkg::CONFIG_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign watchdog_service = s_q.wd_pulse;

	assign rec_en = {s_q.ctrl4[dccb_pkg::C4_ECV_OR],
			 s_q.ctrl4[dccb_pkg::C4_OUT9_OR],
			 s_q.ctrl4[dccb_pkg::C4_OUT8_OR],
			 s_q.ctrl4[dccb_pkg::C4_OUT7_OR],
			 s_q.ctrl4[dccb_pkg::C4_OUT6_OR]};
	assign pwm_gate = {s_q.ctrl4[dccb_pkg::C4_ECV_PWM],
			   s_q.ctrl4[dccb_pkg::C4_OUT9_PWM],
			   s_q.ctrl4[dccb_pkg::C4_OUT8_PWM],
			   s_q.ctrl4[dccb_pkg::C4_OUT7_PWM],
			   s_q.ctrl4[dccb_pkg::C4_OUT6_PWM]};
	// ecv and out9 on a, out8 on c, out7 on a, out6 on b
	assign pwm_src = {pwm_input_a, pwm_input_a, pwm_input_c,
			  pwm_input_a, pwm_input_b};

	for (genvar i = 0; i < dccb_pkg::NUM_OUT; i++) begin : g_out
		dccb_recovery u_rec (
			.clk           (clk),
			.rst           (rst),
			.recovery_en   (rec_en[i]),
			.oc_event      (oc_event[i]),
			.status_clear  (oc_status_clear[i]),
			.recovery_tick (tick),
			.duty_end      (duty_end),
			.oc_status     (oc_status[i]),
			.drive_allow   (allow[i])
		);
		assign drive_on[i] = out_enable[i] && allow[i] &&
				     (!pwm_gate[i] || pwm_src[i]);
	end

	assign monitor_sel = s_q.ctrl4[dccb_pkg::C4_SEL_LSB +: 4];
	always_comb begin
		current_monitor_pin = '0;
		// zero and reserved codes leave the monitor off
		if (monitor_sel != dccb_pkg::SEL_OFF &&
		    monitor_sel <= dccb_pkg::SEL_MAX)
			current_monitor_pin[monitor_sel - 4'h1] = 1'b1;
	end

	assign global_warn_openload_flag =
		(|(openload_status2 & ~16'((1 << dccb_pkg::OL_OUT7) |
					    (1 << dccb_pkg::OL_ECV) |
					    (1 << dccb_pkg::OL_EC_FAST_DISCHARGE_CHANNEL)))) ||
		(!s_q.config_r[dccb_pkg::CF_EC_OL_MASK] &&
		 (openload_status2[dccb_pkg::OL_OUT7] ||
		  openload_status2[dccb_pkg::OL_ECV] ||
		  openload_status2[dccb_pkg::OL_EC_FAST_DISCHARGE_CHANNEL])) ||
		(!s_q.config_r[dccb_pkg::CF_OUT1HS_MASK] &&
		 out1_undercurrent[1]) ||
		(!s_q.config_r[dccb_pkg::CF_OUT1LS_MASK] &&
		 out1_undercurrent[0]) ||
		temp_warning;
	assign global_error_flag = other_errors ||
		(!s_q.config_r[dccb_pkg::CF_TWOL_MASK] &&
		 global_warn_openload_flag);

	always_comb begin
		reg_rdata = '0;
		if (reg_addr == dccb_pkg::ADDR_CTRL4)
			reg_rdata = s_q.ctrl4;
		else if (reg_addr == dccb_pkg::ADDR_CONFIG)
			reg_rdata = s_q.config_r;
	end

	property p_reserved_zero;
		@(posedge clk) disable iff (rst)
		(s_q.ctrl4 & ~dccb_pkg::CTRL4_WMASK) == 16'h0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved control bit set");

	property p_cfg_upper_zero;
		@(posedge clk) disable iff (rst)
		s_q.config_r[15:8] == 8'h00;
	endproperty
	a_cfg_upper_zero: assert property (p_cfg_upper_zero)
		else $error("configuration upper byte not zero");

	property p_pwm_follow;
		@(posedge clk) disable iff (rst)
		(out_enable[2] && allow[2] && pwm_gate[2]) |->
			(drive_on[2] == pwm_input_c);
	endproperty
	a_pwm_follow: assert property (p_pwm_follow)
		else $error("out8 not following pwm c");

	property p_ecv_pwm;
		@(posedge clk) disable iff (rst)
		(out_enable[4] && allow[4] && pwm_gate[4] && !pwm_input_a) |->
			!drive_on[4];
	endproperty
	a_ecv_pwm: assert property (p_ecv_pwm)
		else $error("ecv driven while pwm a low");

	property p_monitor_off;
		@(posedge clk) disable iff (rst)
		(monitor_sel == dccb_pkg::SEL_OFF || monitor_sel > dccb_pkg::SEL_MAX)
			|-> current_monitor_pin == 10'h000;
	endproperty
	a_monitor_off: assert property (p_monitor_off)
		else $error("monitor active for off or reserved code");

	property p_mask_ec;
		@(posedge clk) disable iff (rst)
		(s_q.config_r[dccb_pkg::CF_EC_OL_MASK] && !temp_warning &&
		 out1_undercurrent == 2'b00 &&
		 (openload_status2 & 16'h37ff) == 16'h0000)
			|-> !global_warn_openload_flag;
	endproperty
	a_mask_ec: assert property (p_mask_ec)
		else $error("masked ec open load reached global flag");

	property p_mask_hs;
		@(posedge clk) disable iff (rst)
		(!s_q.config_r[dccb_pkg::CF_OUT1HS_MASK] && out1_undercurrent[1])
			|-> global_warn_openload_flag;
	endproperty
	a_mask_hs: assert property (p_mask_hs)
		else $error("unmasked out1 high open load lost");

	property p_mask_twol;
		@(posedge clk) disable iff (rst)
		(s_q.config_r[dccb_pkg::CF_TWOL_MASK] && !other_errors)
			|-> !global_error_flag;
	endproperty
	a_mask_twol: assert property (p_mask_twol)
		else $error("masked warning reached global error");

	sequence s_cfg_toggle;
		reg_wr && reg_addr == dccb_pkg::ADDR_CONFIG &&
		(reg_wdata[dccb_pkg::CF_WD_TRIG] !=
		 s_q.config_r[dccb_pkg::CF_WD_TRIG]);
	endsequence
	property p_wd_service;
		@(posedge clk) disable iff (rst)
		s_cfg_toggle |-> ##2 watchdog_service;
	endproperty
	a_wd_service: assert property (p_wd_service)
		else $error("watchdog toggle gave no service");
endmodule : dccb_top

/* File: bench/dccb_host.sv */
/*
 * dccb_host: host side of the register port; writes, reads and the
 * control 1 watchdog bit. assumes the caller runs on the same clk.
 */
`timescale 1ns/100ps
module dccb_host (
	// clock
	input  wire logic        clk,
	// register port
	output logic             reg_wr,
	output logic      [5:0]  reg_addr,
	output logic      [15:0] reg_wdata,
	input  wire logic [15:0] reg_rdata,
	// watchdog source
	output logic             ctrl1_wd_bit
);
	initial begin
		{reg_wr, reg_addr, reg_wdata, ctrl1_wd_bit} = 24'h000000;
	end

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
		// stale data is not left on the bus
		reg_wdata = ~d;
	endtask : wr

	task automatic rd(input logic [5:0] a, output logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		#1;
		d = reg_rdata;
	endtask : rd

	task automatic kick();
		@(negedge clk);
		ctrl1_wd_bit = ~ctrl1_wd_bit;
	endtask : kick
endmodule : dccb_host

/* File: bench/tb_driver_control_config_bits.sv */
/*
 * tb_driver_control_config_bits: self-checking bench for dccb_top.
 * assumes dccb_host as the register port master.
 */
`timescale 1ns/100ps
module tb_driver_control_config_bits;
	logic        clk, rst, reg_wr, recovery_rate_select, ctrl1_wd_bit;
	logic        watchdog_service, pwm_input_a, pwm_input_b, pwm_input_c;
	logic        temp_warning, other_errors, global_error_flag;
	logic        global_warn_openload_flag;
	logic [5:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, openload_status2, c4, cf, d;
	logic [4:0]  out_enable, oc_event, oc_status_clear, oc_status, drive_on;
	logic [9:0]  current_monitor_pin;
	logic [1:0]  out1_undercurrent, f;
	logic [31:0] seed;
	int          errors, n_tests, c, n;

	dccb_top i_dccb_top (.clk, .rst, .reg_wr, .reg_addr, .reg_wdata,
		.reg_rdata, .recovery_rate_select, .ctrl1_wd_bit,
		.watchdog_service, .out_enable, .oc_event, .oc_status_clear,
		.oc_status, .drive_on, .pwm_input_a, .pwm_input_b, .pwm_input_c,
		.current_monitor_pin, .openload_status2, .out1_undercurrent,
		.temp_warning, .other_errors, .global_warn_openload_flag,
		.global_error_flag);
	dccb_host i_dccb_host (.clk, .reg_wr, .reg_addr, .reg_wdata,
		.reg_rdata, .ctrl1_wd_bit);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	function automatic logic [31:0] nxt(logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : nxt

	function automatic logic [15:0] mon(logic [3:0] s);
		mon = 16'h0000;
		if (s != 4'h0 && s <= 4'h9)
			mon[s - 4'h1] = 1'b1;
	endfunction : mon

	// gated outputs follow their own pwm input
	function automatic logic [15:0] drv(logic [15:0] g);
		drv = {11'h000, out_enable & ~({g[4], g[11:8]} & ~{pwm_input_a,
			pwm_input_a, pwm_input_c, pwm_input_a, pwm_input_b})};
	endfunction : drv

	function automatic logic [1:0] flg(logic [15:0] m);
		logic o;
		o = |(openload_status2 & ~({16{m[6]}} & 16'hc800)) | temp_warning
			| (out1_undercurrent[1] & ~m[5])
			| (out1_undercurrent[0] & ~m[4]);
		flg = {o, other_errors | (o & ~m[3])};
	endfunction : flg

	task automatic chk(string s, logic [15:0] e, logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s exp %h got %h", s, e, g);
		end
	endtask : chk

	task automatic wrap_up();
		$display("tests %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up

	task automatic hit(input int k, input logic clr);
		@(negedge clk);
		if (clr)
			oc_status_clear[k] = 1'b1;
		else
			oc_event[k] = 1'b1;
		@(negedge clk);
		{oc_event, oc_status_clear} = 10'h000;
	endtask : hit

	task automatic wait_drv(input int k, input logic v, output int t);
		t = 0;
		while (drive_on[k] !== v) begin
			@(posedge clk);
			#1;
			t++;
			if (t > 80000) begin
				errors++;
				wrap_up();
			end
		end
	endtask : wait_drv

	task automatic pulses(output int t);
		t = 0;
		repeat (6) begin
			@(posedge clk);
			#1;
			if (watchdog_service === 1'b1)
				t++;
		end
	endtask : pulses

	initial begin
		{rst, recovery_rate_select, out_enable, oc_event} = 12'h800;
		{oc_status_clear, pwm_input_a, pwm_input_b, pwm_input_c} = 8'h00;
		{openload_status2, out1_undercurrent, temp_warning} = 19'h00000;
		other_errors = 1'b0;
		seed = 32'h6097;
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		i_dccb_host.rd(dccb_pkg::ADDR_CONFIG, d);
		chk("config reset", dccb_pkg::CONFIG_RESET, d);
		for (int i = 0; i < 16; i++) begin
			seed = nxt(seed);
			c4 = {seed[15:4], i[3:0]};
			cf = seed[31:16];
			i_dccb_host.wr(dccb_pkg::ADDR_CTRL4, c4);
			i_dccb_host.wr(dccb_pkg::ADDR_CONFIG, cf);
			i_dccb_host.wr(6'h20, 16'hffff);
			i_dccb_host.rd(dccb_pkg::ADDR_CTRL4, d);
			chk("ctrl4", c4 & dccb_pkg::CTRL4_WMASK, d);
			i_dccb_host.rd(dccb_pkg::ADDR_CONFIG, d);
			chk("config", cf & dccb_pkg::CONFIG_WMASK, d);
			i_dccb_host.rd(6'h20, d);
			chk("unmapped", 16'h0000, d);
			seed = nxt(seed);
			@(negedge clk);
			{pwm_input_a, pwm_input_b, pwm_input_c, out_enable} = seed[7:0];
			{temp_warning, other_errors, out1_undercurrent} = seed[11:8];
			openload_status2 = seed[31:16] & 16'hc800;
			#1;
			f = flg(cf);
			chk("monitor", mon(i[3:0]), current_monitor_pin);
			chk("drive", drv(c4), drive_on);
			chk("ol flag", f[1], global_warn_openload_flag);
			chk("err flag", f[0], global_error_flag);
		end
		i_dccb_host.wr(dccb_pkg::ADDR_CONFIG, 16'h0000);
		repeat (6) @(negedge clk);
		for (int k = 0; k < 4; k++) begin
			if (k[0])
				i_dccb_host.wr(dccb_pkg::ADDR_CONFIG, {15'h0000, ~k[1]});
			else
				i_dccb_host.kick();
			pulses(n);
			chk("wd pulse", 16'h0001, 16'(n));
		end
		@(negedge clk);
		out_enable = 5'h1f;
		recovery_rate_select = 1'b1;
		i_dccb_host.wr(dccb_pkg::ADDR_CTRL4, 16'h1000);
		hit(4, 1'b0);
		chk("ecv status", 16'h0001, oc_status[4]);
		chk("ecv off", 16'h0000, drive_on[4]);
		repeat (50) @(negedge clk);
		chk("ecv held", 16'h0000, drive_on[4]);
		hit(4, 1'b1);
		chk("ecv back", 16'h0001, drive_on[4]);
		hit(0, 1'b0);
		chk("out6 off", 16'h0000, drive_on[0]);
		wait_drv(0, 1'b1, c);
		wait_drv(0, 1'b0, c);
		chk("on time", 16'(dccb_pkg::PER_SLOW * dccb_pkg::DUTY_EIGHTHS / 8),
			16'(c));
		wait_drv(0, 1'b1, n);
		chk("period", 16'(dccb_pkg::PER_FAST), 16'(c + n));
		wrap_up();
	end
endmodule : tb_driver_control_config_bits
